// ### design/sddi_top.sv
// four-axis step/direction drive interface with switch input image
// assumes one 20 MHz clock; switch and controller status pins asynchronous, active-low inputs
// Functional notes
// - one step pulse per commanded step; rising edge advances motor one step
// - direction settles before each step rising edge
// - enable drives power controller; axis unavailable until ready seen
// - pwm duty sets current zero to full nominal
// - any temperature or rotation fault on any axis lights error indicator
// - motor temperature and rotation faults never stop or alter motion
// - twenty switch inputs, five per axis, default function remappable
// - switches appear in process image bits 32 to 51
// - bit 32 is axis one positive limit, functions follow per axis
// - switches debounced, trigger inputs with one tenth settling time
`timescale 1ns/1ps
module sddi_top #(
   parameter int NAXES = sddi_pkg::NUM_AXES,
   parameter int SETTLE = sddi_pkg::SETTLE_CYC,
   parameter int TRIG_SETTLE = sddi_pkg::TRIG_SETTLE_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [NAXES-1:0] i_step_req,
   input wire logic [NAXES-1:0] i_step_dir,
   input wire logic [NAXES-1:0] i_axis_enable,
   input wire logic [NAXES*sddi_pkg::PWM_W-1:0] i_pwm_duty,
   input wire sddi_pkg::sddi_ctrl_in_t [NAXES-1:0] i_ctrl,
   input wire logic [sddi_pkg::NUM_SW-1:0] i_switch_b,
   input wire logic [sddi_pkg::NUM_SW*5-1:0] i_switch_map,
   output sddi_pkg::sddi_ctrl_out_t [NAXES-1:0] o_ctrl,
   output logic [NAXES-1:0] o_step_busy,
   output logic [NAXES-1:0] o_axis_ready,
   output logic [NAXES-1:0] o_axis_fault,
   output logic o_error_led,
   output logic [sddi_pkg::IMG_W-1:0] o_image
);
   import sddi_pkg::*;

   logic [NUM_SW-1:0] sw_level;
   logic [NUM_SW-1:0] img_sw_ff, nxt_img_sw;
   logic error_ff, nxt_error;
   logic [PWM_W-1:0] pwm_cnt_ff, nxt_pwm_cnt;

   // switch debouncing; trigger inputs settle faster for capture accuracy
   genvar s;
   generate
      for (s = 0; s < NUM_SW; s++) begin : g_sw
         localparam int ST = ((s % SW_PER_AXIS) == FN_CAPTURE) ? TRIG_SETTLE : SETTLE;
         sddi_debounce #(.SETTLE(ST)) u_db (
            .i_clk(i_clk),
            .i_rst_b(i_rst_b),
            .i_pin_b(i_switch_b[s]),
            .o_level(sw_level[s])
         );
      end
   endgenerate

   // map field s selects which physical input feeds image bit s; identity is default
   always_comb begin
      logic [4:0] sel;
      sel = 5'h00;
      nxt_img_sw = '0;
      for (int i = 0; i < NUM_SW; i++) begin
         sel = i_switch_map[i*5 +: 5];
         if (sel < 5'(NUM_SW)) begin
            nxt_img_sw[i] = sw_level[sel];
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         img_sw_ff <= '0;
      end else begin
         img_sw_ff <= nxt_img_sw;
      end
   end
   assign o_image = {{(IMG_W-IMG_SW_HI-1){1'b0}}, img_sw_ff, {IMG_SW_LO{1'b0}}};

   // shared pwm ramp: duty ff..ff reads as full scale
   always_comb begin
      nxt_pwm_cnt = (pwm_cnt_ff == {PWM_W{1'b1}}) ? PWM_RST : pwm_cnt_ff + 1'b1;
   end

   logic [NAXES-1:0] fault_any;
   genvar a;
   generate
      for (a = 0; a < NAXES; a++) begin : g_ax
         sddi_step_st_t st_ff, nxt_st;
         logic [STEP_W-1:0] tmr_ff, nxt_tmr;
         logic dir_ff, nxt_dir, en_ff, nxt_en, pwm_ff, nxt_pwm;
         logic [3:0] m1_ff, m2_ff;
         logic [PWM_W-1:0] duty;
         logic rdy;
         assign duty = i_pwm_duty[a*PWM_W +: PWM_W];
         assign rdy = m2_ff[0] & en_ff;
         always_comb begin
            nxt_st = st_ff;
            nxt_tmr = tmr_ff;
            nxt_dir = dir_ff;
            nxt_en = i_axis_enable[a];
            // full duty forced high so 100% really reaches nominal current
            nxt_pwm = (duty == {PWM_W{1'b1}}) ? 1'b1 : (pwm_cnt_ff < duty);
            // faults deliberately absent here: only ready and enable gate steps
            unique case (st_ff)
               SDDI_IDLE: begin
                  if (i_step_req[a] && rdy) begin
                     nxt_dir = i_step_dir[a];
                     nxt_tmr = DIR_SETUP_CYC;
                     nxt_st = SDDI_SETUP;
                  end
               end
               SDDI_SETUP: begin
                  nxt_tmr = tmr_ff - 1'b1;
                  if (tmr_ff == 16'h0001) begin
                     nxt_tmr = STEP_HIGH_CYC;
                     nxt_st = SDDI_HIGH;
                  end
               end
               SDDI_HIGH: begin
                  nxt_tmr = tmr_ff - 1'b1;
                  if (tmr_ff == 16'h0001) begin
                     nxt_tmr = STEP_HIGH_CYC;
                     nxt_st = SDDI_LOW;
                  end
               end
               SDDI_LOW: begin
                  nxt_tmr = tmr_ff - 1'b1;
                  if (tmr_ff == 16'h0001) begin
                     nxt_st = SDDI_IDLE;
                  end
               end
               default: begin
                  nxt_st = SDDI_IDLE;
               end
            endcase
         end
         always_ff @(posedge i_clk or negedge i_rst_b) begin
            if (!i_rst_b) begin
               st_ff <= SDDI_IDLE;
               tmr_ff <= '0;
               dir_ff <= 1'b0;
               en_ff <= 1'b0;
               pwm_ff <= 1'b0;
               m1_ff <= '0;
               m2_ff <= '0;
            end else begin
               st_ff <= nxt_st;
               tmr_ff <= nxt_tmr;
               dir_ff <= nxt_dir;
               en_ff <= nxt_en;
               pwm_ff <= nxt_pwm;
               // order: ready, rotation, driver temp, motor temp
               m1_ff <= ~{i_ctrl[a].motor_temp_warning_b, i_ctrl[a].driver_temp_warning_b,
                          i_ctrl[a].rotation_monitor_error_b, i_ctrl[a].ready_b};
               m2_ff <= m1_ff;
            end
         end
         assign o_ctrl[a].step = (st_ff == SDDI_HIGH);
         assign o_ctrl[a].dir = dir_ff;
         assign o_ctrl[a].enable = en_ff;
         assign o_ctrl[a].pwm = pwm_ff;
         assign o_step_busy[a] = (st_ff != SDDI_IDLE);
         assign o_axis_ready[a] = rdy;
         assign fault_any[a] = |m2_ff[3:1];
         assign o_axis_fault[a] = fault_any[a];
      end
   endgenerate

   always_comb begin
      nxt_error = |fault_any;
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         error_ff <= 1'b0;
         pwm_cnt_ff <= PWM_RST;
      end else begin
         error_ff <= nxt_error;
         pwm_cnt_ff <= nxt_pwm_cnt;
      end
   end
   assign o_error_led = error_ff;
endmodule

// ### design/sddi_pkg.sv
// package for the four-axis step/direction drive interface
// assumes a single 20 MHz clock domain
package sddi_pkg;
   localparam int NUM_AXES = 4;
   localparam int SW_PER_AXIS = 5;
   localparam int NUM_SW = 20;
   localparam int CLK_HZ = 20000000;
   // settling time in microseconds, least figure rounds up
   localparam int SETTLE_US = 1000;
   localparam int TRIG_SETTLE_US = 100;
   localparam int SETTLE_CYC = (SETTLE_US * (CLK_HZ / 1000000));
   localparam int TRIG_SETTLE_CYC = (TRIG_SETTLE_US * (CLK_HZ / 1000000));
   // process image bit positions
   localparam int IMG_SW_LO = 32;
   localparam int IMG_SW_HI = 51;
   localparam int IMG_W = 64;
   // default function of each switch within an axis group
   localparam int FN_POS_LIMIT = 0;
   localparam int FN_NEG_LIMIT = 1;
   localparam int FN_HOME = 2;
   localparam int FN_STOP = 3;
   localparam int FN_CAPTURE = 4;
   localparam int PWM_W = 8;
   localparam logic [PWM_W-1:0] PWM_RST = 8'h00;
   localparam int STEP_W = 16;
   localparam logic [STEP_W-1:0] STEP_HIGH_CYC = 16'h000A;
   localparam logic [STEP_W-1:0] DIR_SETUP_CYC = 16'h0004;

   typedef enum logic [3:0] {
      SDDI_IDLE  = 4'b0001,
      SDDI_SETUP = 4'b0010,
      SDDI_HIGH  = 4'b0100,
      SDDI_LOW   = 4'b1000
   } sddi_step_st_t;

   typedef struct packed {
      logic motor_temp_warning_b;
      logic driver_temp_warning_b;
      logic rotation_monitor_error_b;
      logic ready_b;
   } sddi_ctrl_in_t;

   typedef struct packed {
      logic step;
      logic dir;
      logic enable;
      logic pwm;
   } sddi_ctrl_out_t;
endpackage

// ### design/sddi_debounce.sv
// one synchronised, inverted and debounced switch input
// assumes an asynchronous active-low pin
`timescale 1ns/1ps
module sddi_debounce #(
   parameter int SETTLE = 20000
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_pin_b,
   output logic o_level
);
   import sddi_pkg::*;
   localparam int CW = $clog2(SETTLE + 1);
   localparam logic [CW-1:0] CNT_END = CW'(SETTLE - 1);
   logic meta_ff, sync_ff, level_ff, nxt_level;
   logic [CW-1:0] cnt_ff, nxt_cnt;

   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_level = level_ff;
      // level must stand unchanged for the settling time
      if (sync_ff == level_ff) begin
         nxt_cnt = '0;
      end else if (cnt_ff == CNT_END) begin
         nxt_cnt = '0;
         nxt_level = sync_ff;
      end else begin
         nxt_cnt = cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         level_ff <= 1'b0;
         cnt_ff <= '0;
      end else begin
         meta_ff <= ~i_pin_b;
         sync_ff <= meta_ff;
         level_ff <= nxt_level;
         cnt_ff <= nxt_cnt;
      end
   end
   assign o_level = level_ff;
endmodule

// ### tb/sddi_top_asserts.sv
// checker on the drive interface top ports, axis 0 standing for all
// assumes it is bound into every sddi_top instance
`timescale 1ns/1ps
module sddi_top_asserts import sddi_pkg::*; #(parameter int NAXES = 4) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [NAXES-1:0] i_step_req,
   input wire sddi_ctrl_in_t [NAXES-1:0] i_ctrl,
   input wire sddi_ctrl_out_t [NAXES-1:0] o_ctrl,
   input wire logic [NAXES-1:0] o_step_busy,
   input wire logic [NAXES-1:0] o_axis_ready,
   input wire logic [NAXES-1:0] o_axis_fault,
   input wire logic o_error_led,
   input wire logic [IMG_W-1:0] o_image
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);
   a_step_pulse: assert property ($rose(o_step_busy[0]) |-> ##4 $rose(o_ctrl[0].step) ##10 $fell(o_ctrl[0].step))
      else $error("step pulse timing");
   a_dir_hold: assert property (o_ctrl[0].step |-> $stable(o_ctrl[0].dir)) else $error("dir moved");
   a_take_ready: assert property ($rose(o_step_busy[0]) |-> $past(i_step_req[0] && o_axis_ready[0]))
      else $error("step without ready");
   // ready is the pin two samples back, gated by the enable being driven
   a_ready_en: assert property (o_axis_ready[0] == (o_ctrl[0].enable && !$past(i_ctrl[0].ready_b, 2)))
      else $error("ready mismatch");
   a_take_starts: assert property (i_step_req[0] && o_axis_ready[0] && !o_step_busy[0] |=> o_step_busy[0])
      else $error("step not taken");
   a_led_follow: assert property (o_error_led == |$past(o_axis_fault)) else $error("led mismatch");
   a_fault_sync: assert property (!i_ctrl[0].rotation_monitor_error_b [*3] |-> o_axis_fault[0])
      else $error("fault late");
   a_image_unused: assert property (o_image[31:0] == 0 && o_image[63:52] == 0) else $error("stray image bit");
endmodule

bind sddi_top sddi_top_asserts #(.NAXES(NAXES)) u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_step_req(i_step_req),
   .i_ctrl(i_ctrl), .o_ctrl(o_ctrl), .o_step_busy(o_step_busy), .o_axis_ready(o_axis_ready),
   .o_axis_fault(o_axis_fault), .o_error_led(o_error_led), .o_image(o_image));

// ### tb/sddi_pwr_model.sv
// behavioural power controller for one axis
// assumes the bench supplies faults and ready delay; no reset of its own
`timescale 1ns/1ps
module sddi_pwr_model import sddi_pkg::*; (
   input wire logic i_clk,
   input wire sddi_ctrl_out_t i_ctrl,
   input wire logic [2:0] i_fault,
   input wire logic [3:0] i_dly,
   output sddi_ctrl_in_t o_ctrl_b,
   output int o_pos = 0
);
   logic [3:0] cnt = '0;
   logic step_q = 1'b0;
   always @(posedge i_clk) begin
      step_q <= i_ctrl.step;
      if (i_ctrl.step && !step_q) o_pos <= o_pos + (i_ctrl.dir ? 1 : -1);
      cnt <= !i_ctrl.enable ? '0 : cnt + 4'(cnt != i_dly);
   end
   // open opto inputs read inactive; rotation error whenever i_fault[0] is set
   assign o_ctrl_b = {~i_fault[2], ~i_fault[1], ~i_fault[0], !(i_ctrl.enable && cnt == i_dly)};
endmodule

// ### tb/sddi_top_tb_top.sv
// random and corner tests of the drive interface top
// assumes four controller models and the bound checker
`timescale 1ns/1ps
module sddi_top_tb_top;
   import sddi_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic [3:0] req = '0, dir = '0, en = '0, busy, rdy, flt_a;
   logic [11:0] flt = '0;
   logic [31:0] duty = '0;
   logic [19:0] sw_b = '1;
   logic [99:0] map;
   logic [63:0] img;
   logic led;
   logic [15:0] lf = 16'hE076;
   sddi_ctrl_in_t [3:0] ci;
   sddi_ctrl_out_t [3:0] co;
   int pos [4], want [4] = '{default: 0}, hi [4];
   int n_mismatch = 0, n_checks = 0;
   always #25 i_clk = ~i_clk;
   function automatic logic [15:0] nx(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %0t seen %0h want %0h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   // held request gives one step per 25 cycles
   task automatic step(input int a, input int n);
      lf = nx(lf);
      dir[a] <= lf[0];
      req[a] <= 1'b1;
      want[a] += lf[0] ? n : -n;
      tick(n * 25);
      req[a] <= 1'b0;
      tick(30);
   endtask
   sddi_top #(.SETTLE(8), .TRIG_SETTLE(3)) dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_step_req(req), .i_step_dir(dir),
      .i_axis_enable(en), .i_pwm_duty(duty), .i_ctrl(ci), .i_switch_b(sw_b), .i_switch_map(map), .o_ctrl(co),
      .o_step_busy(busy), .o_axis_ready(rdy), .o_axis_fault(flt_a), .o_error_led(led), .o_image(img));
   for (genvar a = 0; a < 4; a++) begin : g_pwr
      sddi_pwr_model m (.i_clk(i_clk), .i_ctrl(co[a]), .i_fault(flt[a*3+:3]), .i_dly(4'(a * 3 + 1)),
         .o_ctrl_b(ci[a]), .o_pos(pos[a]));
   end
   initial begin
      tick(20000);
      n_mismatch++;
      summarize();
   end
   initial begin
      for (int i = 0; i < 20; i++) map[i*5+:5] <= 5'(i);
      tick(12);
      i_rst_b <= 1'b1;
      tick(2);
      chk(rdy, 4'h0);
      en <= 4'h7;
      tick(20);
      chk(rdy, 4'h7);
      flt[0] <= 1'b1;
      step(3, 1);
      for (int k = 0; k < 6; k++) begin
         lf = nx(lf);
         step(k % 3, lf[2:1] + 1);
      end
      for (int a = 0; a < 3; a++) chk(pos[a], want[a]);
      chk(pos[3], 0);
      for (int f = 0; f < 12; f++) begin
         flt <= 12'h001 << f;
         tick(5);
         chk({flt_a, led}, {4'h1 << (f / 3), 1'b1});
         flt <= '0;
         tick(5);
         chk(led, 1'b0);
      end
      for (int k = 0; k < 3; k++) begin
         lf = nx(lf);
         duty <= k ? {lf, nx(lf)} : 32'h01FE_00FF;
         tick(300);
         hi = '{default: 0};
         repeat (256) begin
            @(posedge i_clk);
            for (int a = 0; a < 4; a++) hi[a] += co[a].pwm;
         end
         for (int a = 0; a < 4; a++) chk(hi[a], duty[a*8+:8] == 8'hFF ? 256 : duty[a*8+:8]);
      end
      for (int k = 0; k < 4; k++) begin
         lf = nx(lf);
         sw_b <= ~{lf[3:0], lf};
         tick(16);
         chk(img, {12'h000, lf[3:0], lf, 32'h0});
      end
      // short glitch must not reach the image
      // looked at while an undebounced or short-settling path would still show it
      sw_b[0] <= ~sw_b[0];
      tick(3);
      sw_b[0] <= ~sw_b[0];
      tick(2);
      chk(img[51:32], 20'(~sw_b));
      tick(3);
      chk(img[51:32], 20'(~sw_b));
      tick(11);
      chk(img[51:32], 20'(~sw_b));
      sw_b <= '1;
      tick(16);
      sw_b <= ~20'h00018;
      tick(8);
      chk(img[36:35], 2'b10);
      tick(8);
      chk(img[36:35], 2'b11);
      map[9:0] <= {5'h19, 5'h04};
      tick(16);
      chk(img[33:32], 2'b01);
      summarize();
   end
endmodule
